// *** src/nrdsc_map.svh ***
// Constants for the ring DMA run and suspend control
`ifndef NRDSC_MAP_SVH
`define NRDSC_MAP_SVH
`define NRDSC_NRINGS 5
`define NRDSC_NTX 4
`define NRDSC_RX_RING 3'h4
`define NRDSC_BASE_W 32
`define NRDSC_LEN_W 16
`define NRDSC_ALIGN_BITS 4
`define NRDSC_ENTRY_BYTES 16'h0010
`define NRDSC_LEN_MAX 16'hffff
`define NRDSC_MISS_W 16
`define NRDSC_ADDR_W 48
`endif

// *** src/nrdsc_pkg.sv ***
// Types for the ring DMA run and suspend control
`default_nettype none
`include "nrdsc_map.svh"
package nrdsc_pkg;
  // Software command bits
  typedef struct packed {
    logic run;
    logic rx_quick_halt_cmd;
    logic rx_drain_halt_cmd;
    logic tx_quick_halt_cmd;
    logic tx_drain_halt_cmd;
  } nrdsc_cmd_t;
  // Status bits shown to software
  typedef struct packed {
    logic rx_suspended;
    logic tx_suspended;
    logic halt_done_irq_flag;
  } nrdsc_stat_t;
  // Per direction state
  typedef enum logic [1:0] {
    NRDSC_OFF,
    NRDSC_RUN,
    NRDSC_DRAIN,
    NRDSC_HALTED
  } nrdsc_dir_t;
  // Descriptor engine state
  typedef enum logic [2:0] {
    NRDSC_IDLE,
    NRDSC_FETCH,
    NRDSC_COPY,
    NRDSC_RELEASE
  } nrdsc_dma_t;
endpackage : nrdsc_pkg
`default_nettype wire

// *** src/nrdsc_ctrl.sv ***
// Run, suspend and descriptor ring control for the network DMA engine
//
// Contract
// R1 - Software loads station address before frames
// R2 - Software sets memory base before accesses
// R3 - Underflow never stops transmitter; no reinit
// R4 - After reset no DMA; only pause frames
// R5 - Run starts polling; clear halts abruptly (code polls a ring only after a demand for it)
// R6 - Quick receive halt after current frame
// R7 - Drain receive halt after FIFO empties
// R8 - Suspended receiver: no DMA, still counts misses
// R9 - Quick transmit halt after current frame
// R10 - Drain transmit halt after FIFO empties
// R11 - Suspended transmitter sends only flow control
// R12 - Software never sets both halts together
// R13 - Transmit and receive suspend independent
// R14 - Software waits on interrupt, paces polls
// R15 - Run clear pulse clears suspend state
// R16 - Restart with halt bits in same write
// R17 - Five rings, own base and length
// R18 - One buffer per descriptor, chaining allowed
// R19 - Receive buffer length rule for software
// R20 - Sixteen byte aligned bases, four-word entries
// R21 - Ownership bit one means controller owns
// R22 - Software reads in order, stops owned
// R23 - Transmit demand polls ring, clears ownership
// R24 - Receive demand polls ring unless owning
// R25 - Halt flag sticky, gated by enable
`default_nettype none
`include "nrdsc_map.svh"
module nrdsc_ctrl (
  // Clock, reset, enable
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  // Software command writes (one-cycle strobes; HALT_IRQ_EN_I is a level)
  input wire logic CMD_WR_I,
  input wire nrdsc_pkg::nrdsc_cmd_t CMD_SET_I,
  input wire nrdsc_pkg::nrdsc_cmd_t CMD_CLR_I,
  input wire logic [`NRDSC_NTX-1:0] TX_RING_DEMAND_I,
  input wire logic RX_RING0_DEMAND_I,
  input wire logic HALT_IRQ_CLR_I,
  input wire logic HALT_IRQ_EN_I,
  // Ring setup
  input wire logic [`NRDSC_NRINGS*`NRDSC_BASE_W-1:0] RING_BASE_I,
  input wire logic [`NRDSC_NRINGS*`NRDSC_LEN_W-1:0] RING_LEN_I,
  input wire logic [`NRDSC_ADDR_W-1:0] STATION_ADDR_I,
  // MAC and FIFO status
  input wire logic MAC_RX_BUSY_I,
  input wire logic MAC_TX_BUSY_I,
  input wire logic RX_FIFO_EMPTY_I,
  input wire logic TX_FIFO_EMPTY_I,
  input wire logic TX_UNDERFLOW_I,
  input wire logic RX_ADDR_MATCH_I,
  input wire logic PAUSE_REQ_I,
  // Descriptor memory port
  output logic DESC_REQ_O,
  output logic DESC_WR_O,
  output logic [`NRDSC_BASE_W-1:0] DESC_ADDR_O,
  input wire logic DESC_ACK_I,
  input wire logic DESC_OWN_I,
  input wire logic DESC_LAST_I,
  input wire logic COPY_DONE_I,
  // Status and gates
  output nrdsc_pkg::nrdsc_cmd_t CMD_O,
  output nrdsc_pkg::nrdsc_stat_t STAT_O,
  output logic [2:0] DMA_RING_O,
  output logic RX_STORE_EN_O,
  output logic TX_FRAME_EN_O,
  output logic TX_PAUSE_ONLY_O,
  output logic [`NRDSC_MISS_W-1:0] MISSED_FRAME_COUNTER_O,
  output logic IRQ_O
);
  import nrdsc_pkg::*;

  // ----------------------------------------
  // Command register
  // ----------------------------------------
  nrdsc_cmd_t cmd_r, cmd_nxt;
  logic run_clr_pulse;
  nrdsc_dir_t rx_st_r, rx_st_nxt, tx_st_r, tx_st_nxt;
  nrdsc_dma_t dma_r, dma_nxt;
  logic halt_flag_r, halt_flag_nxt;
  logic [`NRDSC_MISS_W-1:0] miss_r, miss_nxt;
  logic [`NRDSC_NRINGS-1:0] pend_r, pend_nxt;
  logic [`NRDSC_NRINGS-1:0] owned_r, owned_nxt;
  logic [2:0] ring_r, ring_nxt;
  logic [`NRDSC_LEN_W-1:0] idx_r [`NRDSC_NRINGS];
  logic [`NRDSC_BASE_W-1:0] addr_r, addr_nxt;
  logic desc_last_r;

  // A write that clears run while run is set produces the clear pulse, in the same cycle as the write
  wire run_clearing = CMD_WR_I && CMD_CLR_I.run && cmd_r.run;
  assign run_clr_pulse = run_clearing; // [R15]

  // Next command value; run clear wipes suspend bits
  always_comb begin
    cmd_nxt = cmd_r;
    if (CMD_WR_I) begin
      cmd_nxt = (cmd_r | CMD_SET_I) & ~CMD_CLR_I;
    end
    if (run_clr_pulse) begin
      cmd_nxt = '0; // [R15] [R5]
    end
  end

  // ----------------------------------------
  // Per direction suspend machines
  // ----------------------------------------
  wire rx_halt_req = cmd_r.rx_quick_halt_cmd | cmd_r.rx_drain_halt_cmd;
  wire tx_halt_req = cmd_r.tx_quick_halt_cmd | cmd_r.tx_drain_halt_cmd;
  // Quick halt waits only for MAC, drain also for FIFO
  wire rx_done = !MAC_RX_BUSY_I && (cmd_r.rx_quick_halt_cmd || (RX_FIFO_EMPTY_I && !owned_r[`NRDSC_RX_RING])); // [R6] [R7]
  wire tx_done = !MAC_TX_BUSY_I && (cmd_r.tx_quick_halt_cmd || TX_FIFO_EMPTY_I); // [R9] [R10]

  // Receive direction, independent of transmit
  always_comb begin
    rx_st_nxt = rx_st_r; // [R13]
    case (rx_st_r)
      NRDSC_OFF: if (cmd_r.run) rx_st_nxt = rx_halt_req ? NRDSC_DRAIN : NRDSC_RUN;
      NRDSC_RUN: if (rx_halt_req) rx_st_nxt = NRDSC_DRAIN;
      NRDSC_DRAIN: if (rx_done) rx_st_nxt = NRDSC_HALTED;
      NRDSC_HALTED: if (!rx_halt_req) rx_st_nxt = NRDSC_RUN;
      default: rx_st_nxt = NRDSC_OFF;
    endcase
    if (!cmd_r.run || run_clr_pulse) rx_st_nxt = NRDSC_OFF; // [R5]
  end

  // Transmit direction; underflow has no effect here
  always_comb begin
    tx_st_nxt = tx_st_r; // [R13] [R3]
    case (tx_st_r)
      NRDSC_OFF: if (cmd_r.run) tx_st_nxt = tx_halt_req ? NRDSC_DRAIN : NRDSC_RUN;
      NRDSC_RUN: if (tx_halt_req) tx_st_nxt = NRDSC_DRAIN;
      NRDSC_DRAIN: if (tx_done) tx_st_nxt = NRDSC_HALTED;
      NRDSC_HALTED: if (!tx_halt_req) tx_st_nxt = NRDSC_RUN;
      default: tx_st_nxt = NRDSC_OFF;
    endcase
    if (!cmd_r.run || run_clr_pulse) tx_st_nxt = NRDSC_OFF; // [R5]
  end

  // Entering halted state raises the sticky flag
  wire halt_event = (rx_st_r == NRDSC_DRAIN && rx_st_nxt == NRDSC_HALTED) ||
                    (tx_st_r == NRDSC_DRAIN && tx_st_nxt == NRDSC_HALTED);
  always_comb begin
    halt_flag_nxt = halt_flag_r;
    if (HALT_IRQ_CLR_I) halt_flag_nxt = 1'b0;
    if (halt_event) halt_flag_nxt = 1'b1; // [R25] set wins
    if (run_clr_pulse) halt_flag_nxt = 1'b0; // [R15]
  end

  // ----------------------------------------
  // Gates toward the MAC
  // ----------------------------------------
  wire rx_active = (rx_st_r == NRDSC_RUN) || (rx_st_r == NRDSC_DRAIN && cmd_r.rx_drain_halt_cmd);
  wire tx_active = (tx_st_r == NRDSC_RUN);
  wire rx_dma_ok = rx_active; // [R8] [R4]
  wire tx_dma_ok = tx_active; // [R10]
  wire rx_store_ok = (rx_st_r == NRDSC_RUN); // [R8]
  wire tx_frame_ok = (tx_st_r == NRDSC_RUN) || (tx_st_r == NRDSC_DRAIN && !tx_done); // [R11] [R4]

  // Missed frames counted whenever not storing
  always_comb begin
    miss_nxt = miss_r;
    if (RX_ADDR_MATCH_I && !rx_store_ok) miss_nxt = miss_r + `NRDSC_MISS_W'(1); // [R8] [R4]
  end

  // ----------------------------------------
  // Descriptor engine
  // ----------------------------------------
  wire [`NRDSC_NRINGS-1:0] demand = {RX_RING0_DEMAND_I, TX_RING_DEMAND_I};
  wire [`NRDSC_NRINGS-1:0] ring_ok = {rx_dma_ok, {`NRDSC_NTX{tx_dma_ok}}};
  wire [`NRDSC_NRINGS-1:0] elig = pend_r & ~owned_r & ring_ok;
  logic [2:0] pick;
  logic pick_v;

  // Lowest numbered eligible ring is served first
  always_comb begin
    pick = 3'h0;
    pick_v = 1'b0;
    for (int i = `NRDSC_NRINGS - 1; i >= 0; i--) begin
      if (elig[i]) begin
        pick = 3'(i);
        pick_v = 1'b1;
      end
    end
  end

  wire [`NRDSC_BASE_W-1:0] cur_base = RING_BASE_I[ring_r*`NRDSC_BASE_W +: `NRDSC_BASE_W];
  wire [`NRDSC_LEN_W-1:0] cur_len = RING_LEN_I[ring_r*`NRDSC_LEN_W +: `NRDSC_LEN_W];
  wire [`NRDSC_LEN_W-1:0] cur_idx = idx_r[ring_r];
  // Entry address: aligned base plus sixteen bytes per entry
  wire [`NRDSC_BASE_W-1:0] entry_addr = {cur_base[`NRDSC_BASE_W-1:`NRDSC_ALIGN_BITS], {`NRDSC_ALIGN_BITS{1'b0}}} +
                                       (`NRDSC_BASE_W'(cur_idx) << `NRDSC_ALIGN_BITS); // [R20]
  wire [`NRDSC_LEN_W-1:0] idx_inc = (cur_idx + `NRDSC_LEN_W'(1) >= cur_len) ? '0 : cur_idx + `NRDSC_LEN_W'(1); // [R20]
  wire abort = !ring_ok[ring_r];

  // Engine sequence: fetch, copy one buffer, release ownership
  always_comb begin
    dma_nxt = dma_r;
    ring_nxt = ring_r;
    addr_nxt = addr_r;
    owned_nxt = owned_r;
    pend_nxt = pend_r | demand; // [R23] [R24]
    case (dma_r)
      NRDSC_IDLE: if (pick_v) begin
        ring_nxt = pick; // [R17]
        dma_nxt = NRDSC_FETCH;
      end
      NRDSC_FETCH: if (abort) begin
        dma_nxt = NRDSC_IDLE;
      end else if (DESC_ACK_I) begin
        addr_nxt = entry_addr;
        if (DESC_OWN_I) begin
          owned_nxt[ring_r] = 1'b1; // [R21]
          dma_nxt = NRDSC_COPY;
        end else begin
          pend_nxt[ring_r] = demand[ring_r]; // [R22] wait for demand
          dma_nxt = NRDSC_IDLE;
        end
      end
      NRDSC_COPY: if (abort) begin
        dma_nxt = NRDSC_IDLE;
      end else if (COPY_DONE_I) begin
        dma_nxt = NRDSC_RELEASE; // [R18]
      end
      NRDSC_RELEASE: if (abort) begin
        dma_nxt = NRDSC_IDLE;
      end else if (DESC_ACK_I) begin
        owned_nxt[ring_r] = 1'b0; // [R23] [R21]
        dma_nxt = NRDSC_FETCH; // Poll next entry
      end
      default: dma_nxt = NRDSC_IDLE;
    endcase
    if (!cmd_r.run || run_clr_pulse) begin
      dma_nxt = NRDSC_IDLE; // [R5]
      owned_nxt = '0;
      pend_nxt = cmd_nxt.run ? demand : '0; // [R24] Demand written with run is kept
    end
  end

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      cmd_r <= '0; // [R4]
      rx_st_r <= NRDSC_OFF;
      tx_st_r <= NRDSC_OFF;
      halt_flag_r <= 1'b0;
      miss_r <= '0;
      dma_r <= NRDSC_IDLE;
      ring_r <= 3'h0;
      addr_r <= '0;
      owned_r <= '0;
      pend_r <= '0;
      desc_last_r <= 1'b0;
    end else if (CE_I) begin
      cmd_r <= cmd_nxt;
      rx_st_r <= rx_st_nxt;
      tx_st_r <= tx_st_nxt;
      halt_flag_r <= halt_flag_nxt;
      miss_r <= miss_nxt;
      dma_r <= dma_nxt;
      ring_r <= ring_nxt;
      addr_r <= addr_nxt;
      owned_r <= owned_nxt;
      pend_r <= pend_nxt;
      desc_last_r <= DESC_LAST_I;
    end
  end

  // Ring position per ring, advanced on release
  for (genvar g = 0; g < `NRDSC_NRINGS; g++) begin : g_idx
    always_ff @(posedge CLK_I) begin
      if (RST_I) begin
        idx_r[g] <= '0;
      end else if (CE_I) begin
        if (dma_r == NRDSC_RELEASE && DESC_ACK_I && !abort && ring_r == 3'(g)) begin
          idx_r[g] <= idx_inc; // [R20]
        end
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign DESC_REQ_O = (dma_r == NRDSC_FETCH || dma_r == NRDSC_RELEASE) && !abort;
  assign DESC_WR_O = (dma_r == NRDSC_RELEASE);
  assign DESC_ADDR_O = (dma_r == NRDSC_RELEASE) ? addr_r : entry_addr;
  assign CMD_O = cmd_r;
  assign STAT_O = '{rx_suspended: rx_st_r == NRDSC_HALTED,
                    tx_suspended: tx_st_r == NRDSC_HALTED,
                    halt_done_irq_flag: halt_flag_r};
  assign DMA_RING_O = ring_r;
  assign RX_STORE_EN_O = rx_store_ok;
  assign TX_FRAME_EN_O = tx_frame_ok;
  assign TX_PAUSE_ONLY_O = !tx_frame_ok; // [R11] [R4]
  assign MISSED_FRAME_COUNTER_O = miss_r;
  assign IRQ_O = halt_flag_r && HALT_IRQ_EN_I; // [R25]

endmodule : nrdsc_ctrl
`default_nettype wire

// *** tb/nrdsc_ctrl_monitor.sv ***
// Port assertions for the ring DMA run and suspend control
`default_nettype none
`include "nrdsc_map.svh"
module nrdsc_ctrl_monitor (
  // Watched ports
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  input wire logic HALT_IRQ_CLR_I,
  input wire logic HALT_IRQ_EN_I,
  input wire logic CMD_WR_I,
  input wire logic MAC_RX_BUSY_I,
  input wire logic MAC_TX_BUSY_I,
  input wire logic RX_FIFO_EMPTY_I,
  input wire logic TX_FIFO_EMPTY_I,
  input wire logic RX_ADDR_MATCH_I,
  input wire logic DESC_REQ_O,
  input wire nrdsc_pkg::nrdsc_cmd_t CMD_O,
  input wire nrdsc_pkg::nrdsc_stat_t STAT_O,
  input wire logic RX_STORE_EN_O,
  input wire logic TX_FRAME_EN_O,
  input wire logic TX_PAUSE_ONLY_O,
  input wire logic [`NRDSC_MISS_W-1:0] MISSED_FRAME_COUNTER_O,
  input wire logic IRQ_O
);
  import nrdsc_pkg::*;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  // Gating, idling and clearing
  AST_IRQ_GATE: assert property (IRQ_O == (STAT_O.halt_done_irq_flag & HALT_IRQ_EN_I))
    else $error("irq gate");
  AST_NO_DMA_STOPPED: assert property (!CMD_O.run && !$past(CMD_O.run) |-> !DESC_REQ_O)
    else $error("dma while stopped");
  AST_RX_SUSP_NO_STORE: assert property (STAT_O.rx_suspended |-> !RX_STORE_EN_O)
    else $error("store while halted");
  AST_TX_SUSP_PAUSE: assert property (STAT_O.tx_suspended |-> TX_PAUSE_ONLY_O && !TX_FRAME_EN_O)
    else $error("frames while halted");
  AST_RUN_CLR: assert property ($fell(CMD_O.run) |-> ##[0:2] CMD_O == 5'h00 && STAT_O == 3'h0)
    else $error("run clear");
  AST_FLAG_HOLD: assert property (STAT_O.halt_done_irq_flag && !HALT_IRQ_CLR_I && !CMD_WR_I |=> STAT_O[0])
    else $error("flag dropped");
  // Halt completion timing and missed frame counting
  AST_TX_QUICK: assert property ($rose(CMD_O.tx_quick_halt_cmd) && CMD_O.run && !MAC_TX_BUSY_I |-> ##[1:3] STAT_O[1])
    else $error("quick tx halt late");
  AST_TX_WAITS: assert property ($rose(STAT_O.tx_suspended) |->
    !$past(MAC_TX_BUSY_I) && (!CMD_O.tx_drain_halt_cmd || $past(TX_FIFO_EMPTY_I)))
    else $error("tx halted early");
  AST_RX_WAITS: assert property ($rose(STAT_O.rx_suspended) |->
    !$past(MAC_RX_BUSY_I) && (!CMD_O.rx_drain_halt_cmd || $past(RX_FIFO_EMPTY_I)))
    else $error("rx halted early");
  AST_MISS_COUNT: assert property (CE_I && STAT_O.rx_suspended && RX_ADDR_MATCH_I |=>
    MISSED_FRAME_COUNTER_O == $past(MISSED_FRAME_COUNTER_O) + 1'b1)
    else $error("miss count");
endmodule : nrdsc_ctrl_monitor
bind nrdsc_ctrl nrdsc_ctrl_monitor i_mon (.CLK_I(CLK_I), .RST_I(RST_I), .CE_I(CE_I), .HALT_IRQ_CLR_I(HALT_IRQ_CLR_I),
  .HALT_IRQ_EN_I(HALT_IRQ_EN_I), .CMD_WR_I(CMD_WR_I), .MAC_RX_BUSY_I(MAC_RX_BUSY_I), .MAC_TX_BUSY_I(MAC_TX_BUSY_I),
  .RX_FIFO_EMPTY_I(RX_FIFO_EMPTY_I), .TX_FIFO_EMPTY_I(TX_FIFO_EMPTY_I), .RX_ADDR_MATCH_I(RX_ADDR_MATCH_I),
  .DESC_REQ_O(DESC_REQ_O), .CMD_O(CMD_O), .STAT_O(STAT_O), .RX_STORE_EN_O(RX_STORE_EN_O),
  .TX_FRAME_EN_O(TX_FRAME_EN_O), .TX_PAUSE_ONLY_O(TX_PAUSE_ONLY_O),
  .MISSED_FRAME_COUNTER_O(MISSED_FRAME_COUNTER_O), .IRQ_O(IRQ_O));
`default_nettype wire

// *** tb/nrdsc_mem_model.sv ***
// Behavioural descriptor memory answering the ring engine
`default_nettype none
module nrdsc_mem_model (
  // Engine side
  input wire logic CLK_I,
  input wire logic REQ_I,
  input wire logic WR_I,
  // Answers
  output logic ACK_O,
  output logic OWN_O,
  output logic DONE_O
);
  int owned = 0; // Entries handed to the engine, in ring order
  int slow = 0; // Extra wait per answer
  int n_rel = 0; // Ownership clear writes seen
  int wt = 0;
  logic copy = 1'b0;
  initial begin
    ACK_O = 1'b0;
    OWN_O = 1'b0;
    DONE_O = 1'b0;
  end
  // One answer per request, copy done after each owned entry
  always @(posedge CLK_I) begin
    ACK_O <= 1'b0;
    DONE_O <= 1'b0;
    OWN_O <= ~OWN_O; // Meaningless outside an answer
    if (copy && !REQ_I && !DONE_O) begin
      copy <= 1'b0;
      DONE_O <= 1'b1;
    end else if (REQ_I && !ACK_O && wt < slow) begin
      wt <= wt + 1;
    end else if (REQ_I && !ACK_O) begin
      wt <= 0;
      ACK_O <= 1'b1;
      OWN_O <= !WR_I && owned > 0;
      copy <= !WR_I && owned > 0;
      if (WR_I) begin // only the owner releases
        owned <= owned - 1;
        n_rel <= n_rel + 1;
      end
    end
  end
endmodule : nrdsc_mem_model
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the ring DMA run and suspend control
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import nrdsc_pkg::*;
  logic CLK_I = 1'b0, RST_I = 1'b1, CE_I = 1'b1, CMD_WR_I = 1'b0, RX_RING0_DEMAND_I = 1'b0;
  logic HALT_IRQ_CLR_I = 1'b0, HALT_IRQ_EN_I = 1'b0, MAC_RX_BUSY_I = 1'b0, MAC_TX_BUSY_I = 1'b0;
  logic RX_FIFO_EMPTY_I = 1'b1, TX_FIFO_EMPTY_I = 1'b1, RX_ADDR_MATCH_I = 1'b0, TX_UNDERFLOW_I = 1'b0;
  nrdsc_cmd_t CMD_SET_I = '0, CMD_CLR_I = '0, CMD_O;
  nrdsc_stat_t STAT_O;
  logic [3:0] TX_RING_DEMAND_I = 4'h0;
  logic [159:0] RING_BASE_I = {32'h4000, 32'h3000, 32'h2000, 32'h1000, 32'h0}; // aligned bases
  logic DESC_REQ_O, DESC_WR_O, DESC_ACK_I, DESC_OWN_I, COPY_DONE_I, RX_STORE_EN_O, TX_FRAME_EN_O, TX_PAUSE_ONLY_O, IRQ_O;
  logic [31:0] DESC_ADDR_O;
  logic [2:0] DMA_RING_O;
  logic [15:0] MISSED_FRAME_COUNTER_O;
  int n_fail = 0, compares = 0;
  nrdsc_ctrl i_dut (.CLK_I(CLK_I), .RST_I(RST_I), .CE_I(CE_I), .CMD_WR_I(CMD_WR_I), .CMD_SET_I(CMD_SET_I),
    .CMD_CLR_I(CMD_CLR_I), .TX_RING_DEMAND_I(TX_RING_DEMAND_I), .RX_RING0_DEMAND_I(RX_RING0_DEMAND_I),
    .HALT_IRQ_CLR_I(HALT_IRQ_CLR_I), .HALT_IRQ_EN_I(HALT_IRQ_EN_I), .RING_BASE_I(RING_BASE_I),
    .RING_LEN_I({5{16'h0004}}), .STATION_ADDR_I(48'h0200_0000_0001), // four-entry rings
    .MAC_RX_BUSY_I(MAC_RX_BUSY_I), .MAC_TX_BUSY_I(MAC_TX_BUSY_I), .RX_FIFO_EMPTY_I(RX_FIFO_EMPTY_I),
    .TX_FIFO_EMPTY_I(TX_FIFO_EMPTY_I), .TX_UNDERFLOW_I(TX_UNDERFLOW_I), .RX_ADDR_MATCH_I(RX_ADDR_MATCH_I),
    .PAUSE_REQ_I(1'b0), .DESC_REQ_O(DESC_REQ_O), .DESC_WR_O(DESC_WR_O), .DESC_ADDR_O(DESC_ADDR_O),
    .DESC_ACK_I(DESC_ACK_I), .DESC_OWN_I(DESC_OWN_I), .DESC_LAST_I(1'b1), .COPY_DONE_I(COPY_DONE_I),
    .CMD_O(CMD_O), .STAT_O(STAT_O), .DMA_RING_O(DMA_RING_O), .RX_STORE_EN_O(RX_STORE_EN_O),
    .TX_FRAME_EN_O(TX_FRAME_EN_O), .TX_PAUSE_ONLY_O(TX_PAUSE_ONLY_O),
    .MISSED_FRAME_COUNTER_O(MISSED_FRAME_COUNTER_O), .IRQ_O(IRQ_O));
  nrdsc_mem_model i_mem (.CLK_I(CLK_I), .REQ_I(DESC_REQ_O), .WR_I(DESC_WR_O), .ACK_O(DESC_ACK_I),
    .OWN_O(DESC_OWN_I), .DONE_O(COPY_DONE_I));
  initial forever #10 CLK_I = ~CLK_I;
  // Helpers
  task automatic tick(int n = 1);
    repeat (n) @(posedge CLK_I);
    #1;
  endtask : tick
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
      n_fail++;
    end
  endtask : chk
  task automatic wcmd(nrdsc_cmd_t s, nrdsc_cmd_t c);
    CMD_SET_I = s;
    CMD_CLR_I = c;
    CMD_WR_I = 1'b1;
    tick();
    CMD_WR_I = 1'b0;
  endtask : wcmd
  task automatic match();
    RX_ADDR_MATCH_I = 1'b1;
    tick();
    RX_ADDR_MATCH_I = 1'b0;
    tick();
  endtask : match
  // Bounded wait on a status bit, or on the release count when k is 3
  task automatic wait_on(int k, int tgt);
    int i;
    for (i = 0; i < 200; i++) begin
      if (k < 3 ? STAT_O[k] === 1'b1 : i_mem.n_rel == tgt) break;
      tick(); // one paced poll per cycle
    end
    if (i == 200) begin
      $display("[ERR] %0t wait ran out", $time);
      n_fail++;
      finish_test();
    end
  endtask : wait_on
  task automatic finish_test();
    if (n_fail == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test
  // Scenarios
  task automatic sc_reset();
    chk({CMD_O, STAT_O, TX_PAUSE_ONLY_O, RX_STORE_EN_O, TX_FRAME_EN_O}, 32'h4);
    match();
    chk(MISSED_FRAME_COUNTER_O, 1);
    CE_I = 1'b0;
    match();
    CE_I = 1'b1;
    chk(MISSED_FRAME_COUNTER_O, 1); // frozen while disabled
    TX_RING_DEMAND_I = 4'h1;
    tick();
    TX_RING_DEMAND_I = 4'h0;
    tick(3);
    chk(DESC_REQ_O, 0);
  endtask : sc_reset
  task automatic sc_dma();
    wcmd(5'h10, 5'h00);
    i_mem.owned = 2;
    i_mem.slow = 2;
    TX_RING_DEMAND_I = 4'h4;
    tick();
    TX_RING_DEMAND_I = 4'h0;
    wait_on(3, 2);
    chk(DMA_RING_O, 2);
    tick(8);
    chk(DESC_REQ_O, 0);
    i_mem.owned = 1;
    i_mem.slow = 0;
    RX_RING0_DEMAND_I = 1'b1;
    tick();
    RX_RING0_DEMAND_I = 1'b0;
    wait_on(3, 3);
    chk(DMA_RING_O, 4);
  endtask : sc_dma
  task automatic sc_txq();
    TX_UNDERFLOW_I = 1'b1;
    tick();
    TX_UNDERFLOW_I = 1'b0;
    chk(TX_FRAME_EN_O, 1);
    HALT_IRQ_EN_I = 1'b1;
    wcmd(5'h02, 5'h00);
    wait_on(1, 0);
    chk({STAT_O, TX_PAUSE_ONLY_O, RX_STORE_EN_O, IRQ_O}, 32'h1f);
    HALT_IRQ_EN_I = 1'b0;
    HALT_IRQ_CLR_I = 1'b1;
    tick();
    HALT_IRQ_CLR_I = 1'b0;
    tick();
    chk({STAT_O, IRQ_O}, 32'h4);
  endtask : sc_txq
  task automatic sc_rxq();
    MAC_RX_BUSY_I = 1'b1;
    wcmd(5'h08, 5'h00);
    tick(4);
    chk(STAT_O, 3'h2);
    MAC_RX_BUSY_I = 1'b0;
    wait_on(2, 0);
    chk(STAT_O, 3'h7);
    match();
    chk(MISSED_FRAME_COUNTER_O, 2);
  endtask : sc_rxq
  task automatic sc_restart();
    wcmd(5'h00, 5'h10);
    tick(2);
    chk({CMD_O, STAT_O}, 0);
    TX_FIFO_EMPTY_I = 1'b0;
    MAC_TX_BUSY_I = 1'b1;
    RX_RING0_DEMAND_I = 1'b1;
    wcmd(5'h15, 5'h00); // one halt kind per direction
    RX_RING0_DEMAND_I = 1'b0;
    tick(6);
    chk(STAT_O, 3'h5);
    TX_FIFO_EMPTY_I = 1'b1;
    tick(2);
    chk(STAT_O, 3'h5);
    MAC_TX_BUSY_I = 1'b0;
    wait_on(1, 0);
    TX_RING_DEMAND_I = 4'h1;
    tick();
    TX_RING_DEMAND_I = 4'h0;
    tick(3);
    chk({DESC_REQ_O, TX_FRAME_EN_O}, 0);
    wcmd(5'h00, 5'h04);
    tick(2);
    chk({STAT_O[2], DESC_REQ_O, DESC_WR_O}, 3'h2);
    chk(DESC_ADDR_O, 32'h4010);
  endtask : sc_restart
  // Main sequence
  initial begin
    // Station address and ring setup stand before the first command
    tick(4);
    RST_I = 1'b0;
    tick();
    sc_reset();
    sc_dma();
    sc_txq();
    sc_rxq();
    sc_restart();
    finish_test();
  end
endmodule : testbench
`default_nettype wire
